//--- src/sxc_pkg.sv
// What this block does
// - Status codes are reported with prescaler bits zero.
// - Respond as slave to the address in own-address bits 7:1.
// - Own-address bit 0 set also answers general call 0x00.
// - Address match with read bit enters transmit mode, else receive mode.
// - After address and direction, set interrupt flag with valid status.
// - Lost arbitration then addressed for read reports status 0xB0.
// - Ack-enable cleared sends last byte; NACK gives 0xC0, ACK gives 0xC8.
// - After the last byte, go not-addressed; master then reads all ones.
// - Ack-enable zero refuses own address; recognition resumes when set.
// - STOP or repeated START while addressed sets flag with status 0xA0.
// - Flag clear in 0xA0/0xC0/0xC8 leaves session; ack-enable selects recognition.
// - Not addressed, general call answered only when its enable bit is one.
// - Flag clear in 0xA0/0xC0/0xC8 with start set and stop clear queues a START for when bus is free.
// - In deep sleep, ack-enable set still recognises address on bus clock.
// - Wake-up match wakes part and holds SCL low until flag cleared.
// - Status 0xA8 means own address with read received and acknowledged.
// - Ack-enable after loading a byte selects last byte or more bytes.
// - In deep sleep, each completed address byte loads the data register with all ones (0xFF).
package sxc_pkg;
  // ------------------------------------------------------------------
  // Register byte addresses (word index times four)
  // ------------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STAT = 4'h4;
  localparam logic [3:0] ADDR_DATA = 4'h8;
  localparam logic [3:0] ADDR_OWN = 4'hC;
  // ------------------------------------------------------------------
  // Control field positions
  // ------------------------------------------------------------------
  localparam int CTL_INT = 7;
  localparam int CTL_ACK = 6;
  localparam int CTL_STA = 5;
  localparam int CTL_STO = 4;
  localparam int CTL_EN = 2;
  localparam int CTL_SLEEP = 0;
  localparam int OWN_GC = 0;
  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] OWN_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'hFF;
  // ------------------------------------------------------------------
  // Status codes
  // ------------------------------------------------------------------
  localparam logic [7:0] ST_IDLE = 8'hF8;
  localparam logic [7:0] ST_SR_ADDR = 8'h60;
  localparam logic [7:0] ST_SR_GC = 8'h70;
  localparam logic [7:0] ST_STOP = 8'hA0;
  localparam logic [7:0] ST_ADDR = 8'hA8;
  localparam logic [7:0] ST_ARB = 8'hB0;
  localparam logic [7:0] ST_ACK = 8'hB8;
  localparam logic [7:0] ST_NACK = 8'hC0;
  localparam logic [7:0] ST_LAST = 8'hC8;
  localparam logic [7:0] ONES = 8'hFF;
  localparam logic [6:0] GC_ADDR = 7'h00;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_ADDR = 3'b001,
    S_ACKA = 3'b010,
    S_TX = 3'b011,
    S_RACK = 3'b100,
    S_WAIT = 3'b101,
    S_IGN = 3'b110,
    S_RX = 3'b111
  } sxc_state_t;
endpackage

//--- src/sxc_sync.sv
`timescale 1ns/1ns
module sxc_sync
  import sxc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Raw pin and synchronised level
  input wire logic din,
  output logic dout
);
  logic meta_ff;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      meta_ff <= 1'b1;
      dout <= 1'b1;
    end else begin
      meta_ff <= din;
      dout <= meta_ff;
    end
  end
endmodule

//--- src/sxc_cond.sv
`timescale 1ns/1ns
module sxc_cond
  import sxc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Synchronised bus lines
  input wire logic scl_s,
  input wire logic sda_s,
  // Bus events, one-cycle pulses, and the bus busy level
  output logic scl_rise,
  output logic scl_fall,
  output logic start_det,
  output logic stop_det,
  output logic bus_busy
);
  logic scl_ff;
  logic sda_ff;
  logic busy_ff;
  assign scl_rise = scl_s & ~scl_ff;
  assign scl_fall = ~scl_s & scl_ff;
  assign start_det = scl_s & scl_ff & sda_ff & ~sda_s;
  assign stop_det = scl_s & scl_ff & ~sda_ff & sda_s;
  assign bus_busy = busy_ff;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      scl_ff <= 1'b1;
      sda_ff <= 1'b1;
      busy_ff <= 1'b0;
    end else begin
      scl_ff <= scl_s;
      sda_ff <= sda_s;
      busy_ff <= start_det ? 1'b1 : (stop_det ? 1'b0 : busy_ff);
    end
  end
endmodule

//--- src/sxc_top.sv
// The register offsets and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ns
module sxc_top
  import sxc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Two-wire bus pins
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // System side
  input wire logic arb_lost,
  output logic wake_req,
  output logic start_pending
);
  // ------------------------------------------------------------------
  // Pin synchronisers and bus conditions
  // ------------------------------------------------------------------
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic bus_busy;
  sxc_sync u_sync_scl (.clk(clk), .resetn(resetn), .din(scl_i), .dout(scl_s));
  sxc_sync u_sync_sda (.clk(clk), .resetn(resetn), .din(sda_i), .dout(sda_s));
  sxc_cond u_cond (
    .clk(clk),
    .resetn(resetn),
    .scl_s(scl_s),
    .sda_s(sda_s),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_det(start_det),
    .stop_det(stop_det),
    .bus_busy(bus_busy)
  );
  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  sxc_state_t state_ff;
  sxc_state_t nxt_state;
  logic [7:0] ctrl_ff;
  logic [7:0] own_ff;
  logic [7:0] data_ff;
  logic [7:0] stat_ff;
  logic [7:0] shift_ff;
  logic [3:0] bit_ff;
  logic last_ff;
  logic arb_ff;
  logic sleep_hit_ff;
  logic sda_drv_ff;
  logic scl_hold_ff;
  logic sta_q_ff;
  logic [31:0] rdata_ff;
  logic rsp_ff;
  // ------------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------------
  function automatic logic sel(input logic [3:0] a, input logic [3:0] r);
    return a == r;
  endfunction
  wire req = (avs_read | avs_write) & ~rsp_ff;
  wire wr = avs_write & ~rsp_ff;
  wire wr_ctrl = wr & sel(avs_address, ADDR_CTRL);
  wire wr_data = wr & sel(avs_address, ADDR_DATA);
  wire wr_own = wr & sel(avs_address, ADDR_OWN);
  wire flag = ctrl_ff[CTL_INT];
  wire ack_en = ctrl_ff[CTL_ACK];
  wire en = ctrl_ff[CTL_EN];
  wire in_sleep = ctrl_ff[CTL_SLEEP];
  // Writing one to the flag clears it
  wire flag_clr = wr_ctrl & avs_writedata[CTL_INT] & flag;
  wire [6:0] rx_addr = shift_ff[6:0];
  // Own address in bits 7:1, general call gated by bit 0
  wire own_hit = rx_addr == own_ff[7:1];
  wire gc_hit = (rx_addr == GC_ADDR) & own_ff[OWN_GC];
  wire is_read = shift_ff[0];
  // Address byte complete on the 8th rising edge
  wire addr_done = (state_ff == S_ADDR) & scl_rise & (bit_ff == 4'h7);
  wire [7:0] addr_byte = {shift_ff[6:0], sda_s};
  wire a_own = addr_byte[7:1] == own_ff[7:1];
  wire a_gc = (addr_byte[7:1] == GC_ADDR) & own_ff[OWN_GC];
  // Recognition only while enabled and acking
  wire a_match = en & ack_en & (a_own | (a_gc & ~addr_byte[0]));
  wire addressed = (state_ff == S_ACKA) | (state_ff == S_TX) |
                   (state_ff == S_RACK) | (state_ff == S_WAIT) |
                   (state_ff == S_RX);
  wire session_end = (start_det | stop_det) & addressed;
  wire tx_bit = shift_ff[7];
  wire rack_sample = (state_ff == S_RACK) & scl_rise;
  wire [7:0] rack_stat = sda_s ? ST_NACK : (last_ff ? ST_LAST : ST_ACK);
  wire [7:0] addr_stat = ~addr_byte[0] ? (a_own ? ST_SR_ADDR : ST_SR_GC) :
                         (arb_ff ? ST_ARB : ST_ADDR);
  wire end_state = (stat_ff == ST_NACK) | (stat_ff == ST_LAST) | (stat_ff == ST_STOP);
  // ------------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      S_IDLE: if (start_det && en) nxt_state = S_ADDR;
      S_ADDR: if (addr_done) nxt_state = a_match ? S_ACKA : S_IGN;
      S_ACKA: if (scl_fall && !flag) nxt_state = is_read ? S_TX : S_RX;
      S_TX: if (scl_fall && bit_ff == 4'h7) nxt_state = S_RACK;
      S_RACK: if (rack_sample) nxt_state = S_WAIT;
      S_WAIT: if (flag_clr) nxt_state = end_state ? S_IGN : S_TX;
      S_IGN: if (start_det && en) nxt_state = S_ADDR;
      // Receive data is not handled here; the session stays addressed until STOP or repeated START
      S_RX: nxt_state = S_RX;
    endcase
    if (session_end) nxt_state = start_det ? S_ADDR : S_IGN;
  end
  // ------------------------------------------------------------------
  // Datapath
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_ff <= S_IDLE;
      shift_ff <= 8'h00;
      bit_ff <= 4'h0;
      last_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (start_det) begin
        bit_ff <= 4'h0;
      end else if (state_ff == S_ADDR && scl_rise) begin
        shift_ff <= addr_byte;
        bit_ff <= bit_ff + 4'h1;
      end else if (state_ff == S_ACKA && scl_fall && !flag) begin
        shift_ff <= data_ff;
        bit_ff <= 4'h0;
        last_ff <= ~ack_en;
      end else if (state_ff == S_TX && scl_fall && bit_ff != 4'h7) begin
        shift_ff <= {shift_ff[6:0], 1'b1};
        bit_ff <= bit_ff + 4'h1;
      end else if (state_ff == S_WAIT && flag_clr) begin
        shift_ff <= data_ff;
        bit_ff <= 4'h0;
        last_ff <= ~ack_en;
      end
    end
  end
  // Released SDA reads as ones to the master once not addressed
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sda_drv_ff <= 1'b0;
    end else if (state_ff == S_TX && scl_fall) begin
      sda_drv_ff <= (bit_ff == 4'h7) ? 1'b0 : ~shift_ff[6];
    end else if (state_ff == S_ACKA && scl_fall && !flag) begin
      sda_drv_ff <= is_read ? ~data_ff[7] : 1'b0;
    end else if (state_ff == S_ACKA && scl_fall) begin
      // ACK only once SCL is low, so it never looks like a START
      sda_drv_ff <= 1'b1;
    end else if (state_ff == S_WAIT && flag_clr && !end_state) begin
      // First bit of the next byte must stand before SCL is let go
      sda_drv_ff <= ~data_ff[7];
    end else if (scl_fall || session_end || state_ff == S_IGN) begin
      sda_drv_ff <= 1'b0;
    end
  end
  // Stretch while flag is up in S_ACKA or S_WAIT with SCL low, or after a sleep match
  always_ff @(posedge clk) begin
    if (!resetn) begin
      scl_hold_ff <= 1'b0;
    end else begin
      scl_hold_ff <= (flag & ((state_ff == S_ACKA) | (state_ff == S_WAIT)) & ~scl_s) |
                     (sleep_hit_ff & flag);
    end
  end
  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  wire set_flag = (addr_done & a_match) | rack_sample | session_end;
  wire [7:0] set_stat = addr_done ? addr_stat : (rack_sample ? rack_stat : ST_STOP);
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ctrl_ff <= CTRL_RST;
      stat_ff <= ST_IDLE;
      own_ff <= OWN_RST;
      data_ff <= DATA_RST;
      arb_ff <= 1'b0;
      sleep_hit_ff <= 1'b0;
      sta_q_ff <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff[CTL_ACK] <= avs_writedata[CTL_ACK];
        ctrl_ff[CTL_STA] <= avs_writedata[CTL_STA];
        ctrl_ff[CTL_STO] <= avs_writedata[CTL_STO];
        ctrl_ff[CTL_EN] <= avs_writedata[CTL_EN];
        ctrl_ff[CTL_SLEEP] <= avs_writedata[CTL_SLEEP];
      end
      // Hardware set wins over a simultaneous clear
      if (set_flag) begin
        ctrl_ff[CTL_INT] <= 1'b1;
        stat_ff <= set_stat;
      end else if (flag_clr) begin
        ctrl_ff[CTL_INT] <= 1'b0;
        stat_ff <= ST_IDLE;
      end
      if (wr_own) own_ff <= avs_writedata[7:0];
      if (wr_data) data_ff <= avs_writedata[7:0];
      else if (addr_done && in_sleep) data_ff <= ONES;
      if (arb_lost) arb_ff <= 1'b1;
      else if (addr_done) arb_ff <= 1'b0;
      if (addr_done && a_match && in_sleep) sleep_hit_ff <= 1'b1;
      else if (flag_clr) sleep_hit_ff <= 1'b0;
      // Queued START waits for a free bus
      if (flag_clr && end_state && avs_writedata[CTL_STA] && !avs_writedata[CTL_STO])
        sta_q_ff <= 1'b1;
      else if (sta_q_ff && !bus_busy) sta_q_ff <= 1'b0;
    end
  end
  // ------------------------------------------------------------------
  // Bus slave: one wait cycle per access
  // ------------------------------------------------------------------
  wire [7:0] rmux = sel(avs_address, ADDR_CTRL) ? ctrl_ff :
                    sel(avs_address, ADDR_STAT) ? stat_ff :
                    sel(avs_address, ADDR_DATA) ? data_ff :
                    sel(avs_address, ADDR_OWN) ? own_ff : 8'h00;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rsp_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
    end else begin
      rsp_ff <= req;
      if (req && avs_read) rdata_ff <= {24'h000000, rmux};
    end
  end
  always_ff @(posedge clk) begin
    if (!resetn) begin
      scl_o <= 1'b0;
      scl_oe <= 1'b0;
      sda_o <= 1'b0;
      sda_oe <= 1'b0;
      wake_req <= 1'b0;
      start_pending <= 1'b0;
    end else begin
      scl_oe <= scl_hold_ff;
      sda_oe <= sda_drv_ff;
      wake_req <= sleep_hit_ff;
      start_pending <= sta_q_ff & ~bus_busy;
    end
  end
  assign avs_readdata = rdata_ff;
  assign avs_waitrequest = ~rsp_ff;
endmodule

//--- tb/sxc_mst.sv
`timescale 1ns/1ns
// ----------------------------------------
// Master receiver on the far side
// ----------------------------------------
module sxc_mst (
  // Clock
  input wire logic clk,
  // Device pull-down enables
  input wire logic scl_oe,
  input wire logic sda_oe,
  // Resolved lines, pulled up when released
  output logic scl,
  output logic sda
);
  logic ms = 1'b1;
  logic md = 1'b1;
  int lag = 0;
  assign scl = ms & !scl_oe;
  assign sda = md & !sda_oe;
  // Waits out stretching, bounded so a stuck line cannot hang us
  task automatic rise();
    int n;
    n = 0;
    ms <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (!scl && n < 5000);
  endtask
  task automatic bit_io(input logic b, output logic r);
    md <= b;
    repeat (4 + lag) @(posedge clk);
    rise();
    repeat (3) @(posedge clk);
    r = sda;
    ms <= 1'b0;
  endtask
  task automatic start();
    rise();
    md <= 1'b0;
    repeat (4) @(posedge clk);
    ms <= 1'b0;
  endtask
  task automatic stop();
    md <= 1'b0;
    repeat (4) @(posedge clk);
    rise();
    repeat (3) @(posedge clk);
    md <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic rd(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(!ack, r);
  endtask
endmodule

//--- tb/sxc_assertions.sv
`timescale 1ns/1ns
// ----------------------------------------
// Port checker
// ----------------------------------------
module sxc_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register bus
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Bus pins
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  // System side
  input wire logic arb_lost,
  input wire logic wake_req,
  input wire logic start_pending
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  // Three high samples: the last fall has settled through the sync stages
  sequence s_scl_high;
    scl_i [*3];
  endsequence
  a_req_answer: assert property (s_req |=> !avs_waitrequest)
    else $error("request not answered in one cycle");
  a_answer_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer held longer than one cycle");
  a_read_upper: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_unmapped_zero: assert property ((avs_read && avs_waitrequest &&
    avs_address[1:0] != 2'h0) |=> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_open_drain: assert property (!scl_o && !sda_o)
    else $error("pin driven high");
  a_sda_steady: assert property (s_scl_high |-> $stable(sda_oe))
    else $error("data changed while clock high");
  a_wake_stretch: assert property ($rose(wake_req) |-> ##[0:60] scl_oe)
    else $error("wake match without clock stretch");
  a_start_pulse: assert property (start_pending |=> !start_pending)
    else $error("queued start longer than one cycle");
endmodule

//--- tb/sxc_top_tb.sv
`timescale 1ns/1ns
// ----------------------------------------
// Bench top
// ----------------------------------------
module sxc_top_tb
  import sxc_pkg::*;
;
  localparam logic [6:0] SADDR = 7'h2A;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, scl_i, scl_o, scl_oe, sda_i, sda_o, sda_oe;
  logic arb_lost = 1'b0;
  logic wake_req, start_pending;
  int n_errors = 0;
  int compares = 0;
  int n_start = 0;
  always #10 clk = !clk;
  always @(posedge clk) if (start_pending === 1'b1) n_start <= n_start + 1;
  sxc_top u_dut (.clk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .scl_i, .scl_o, .scl_oe, .sda_i, .sda_o, .sda_oe,
    .arb_lost, .wake_req, .start_pending);
  sxc_mst u_mst (.clk, .scl_oe, .sda_oe, .scl(scl_i), .sda(sda_i));
  task automatic check(input logic [31:0] s, input logic [31:0] e, input string m);
    compares++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED %0t %s got %h want %h", $time, m, s, e);
    end
  endtask
  // Request held until the rising edge that samples waitrequest low
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
    output logic [31:0] q);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_read <= !w;
    avs_write <= w;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    if (avs_waitrequest !== 1'b0) n_errors++;
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    check(q, {24'h0, e}, "register read");
  endtask
  task automatic wflag();
    logic [31:0] q;
    int n;
    q = 32'h0;
    n = 0;
    while (q[CTL_INT] !== 1'b1 && n < 400) begin
      bus(1'b0, ADDR_CTRL, 8'h00, q);
      n++;
    end
    check({31'h0, q[CTL_INT]}, 32'h1, "flag not set");
  endtask
  task automatic probe(input logic [7:0] own, input logic [7:0] ctl, input logic [7:0] b);
    logic a;
    wreg(ADDR_OWN, own);
    wreg(ADDR_CTRL, ctl);
    u_mst.start();
    u_mst.wr(b, a);
    u_mst.stop();
    check({31'h0, a}, 32'h0, "refused address acked");
    $display("probe %h done", b);
  endtask
  task automatic one(input logic [7:0] st0, input logic mack, input logic [7:0] st1,
    input logic [7:0] d, input logic wk);
    logic a;
    logic [7:0] q, z;
    z = 8'h00;
    fork
      begin
        u_mst.start();
        u_mst.wr({SADDR, 1'b1}, a);
        u_mst.rd(mack, q);
        if (mack)
          u_mst.rd(1'b0, z);
        u_mst.stop();
      end
      begin
        wflag();
        @(negedge clk);
        check({31'h0, wake_req}, {31'h0, wk}, "wake request");
        @(posedge clk);
        rchk(ADDR_STAT, st0);
        wreg(ADDR_DATA, d);
        wreg(ADDR_CTRL, 8'h84);
        wflag();
        rchk(ADDR_STAT, st1);
        wreg(ADDR_CTRL, 8'hC4);
      end
    join
    @(negedge clk);
    check({31'h0, wake_req}, 32'h0, "wake held");
    @(posedge clk);
    check({24'h0, q}, {24'h0, d}, "read byte");
    if (mack)
      check({24'h0, z}, {24'h0, ONES}, "data after last");
    $display("session %h done", st1);
  endtask
  task automatic t_tx();
    logic a;
    logic [7:0] d0, d1;
    wreg(ADDR_OWN, {SADDR, 1'b0});
    wreg(ADDR_CTRL, 8'h44);
    u_mst.lag = 6;
    fork
      begin
        u_mst.start();
        u_mst.wr({SADDR, 1'b1}, a);
        u_mst.rd(1'b1, d0);
        u_mst.rd(1'b0, d1);
        u_mst.stop();
      end
      begin
        wflag();
        rchk(ADDR_STAT, ST_ADDR);
        wreg(ADDR_DATA, 8'h5A);
        wreg(ADDR_CTRL, 8'hC4);
        wflag();
        rchk(ADDR_STAT, ST_ACK);
        wreg(ADDR_DATA, 8'hC3);
        wreg(ADDR_CTRL, 8'h84);
        wflag();
        rchk(ADDR_STAT, ST_NACK);
        wreg(ADDR_CTRL, 8'hC4);
      end
    join
    u_mst.lag = 0;
    check({31'h0, a}, 32'h1, "address not acked");
    check({24'h0, d0}, 32'h5A, "first byte");
    check({24'h0, d1}, 32'hC3, "last byte");
    rchk(ADDR_STAT, ST_IDLE);
    $display("transmit test done");
  endtask
  task automatic t_gc();
    logic a;
    int s0, n;
    s0 = n_start;
    n = 0;
    wreg(ADDR_OWN, {SADDR, 1'b1});
    wreg(ADDR_CTRL, 8'h44);
    fork
      begin
        u_mst.start();
        u_mst.wr({GC_ADDR, 1'b0}, a);
        u_mst.stop();
      end
      begin
        wflag();
        rchk(ADDR_STAT, ST_SR_GC);
        wreg(ADDR_CTRL, 8'hC4);
        wflag();
        rchk(ADDR_STAT, ST_STOP);
        wreg(ADDR_CTRL, 8'hE4);
      end
    join
    while (n_start == s0 && n < 200) begin
      @(posedge clk);
      n++;
    end
    check({31'h0, a}, 32'h1, "general call not acked");
    check(n_start - s0, 32'h1, "queued start");
    $display("general call test done");
  endtask
  task automatic end_of_test();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rchk(ADDR_CTRL, CTRL_RST);
    rchk(ADDR_OWN, OWN_RST);
    rchk(ADDR_DATA, DATA_RST);
    rchk(ADDR_STAT, ST_IDLE);
    wreg(4'h1, 8'hA5);
    rchk(4'h1, 8'h00);
    $display("reset test done");
    t_tx();
    probe({SADDR, 1'b1}, 8'h04, {SADDR, 1'b1});
    probe({SADDR, 1'b0}, 8'h44, {SADDR ^ 7'h01, 1'b1});
    probe({SADDR, 1'b0}, 8'h44, 8'h00);
    one(ST_ADDR, 1'b1, ST_LAST, 8'h96, 1'b0);
    arb_lost <= 1'b1;
    @(posedge clk);
    arb_lost <= 1'b0;
    one(ST_ARB, 1'b0, ST_NACK, 8'h3C, 1'b0);
    wreg(ADDR_CTRL, 8'h45);
    one(ST_ADDR, 1'b0, ST_NACK, 8'hE1, 1'b1);
    t_gc();
    end_of_test();
  end
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    end_of_test();
  end
endmodule
bind sxc_top sxc_chk u_chk (.clk, .resetn, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_readdata, .avs_waitrequest, .scl_i, .scl_o, .scl_oe, .sda_i,
  .sda_o, .sda_oe, .arb_lost, .wake_req, .start_pending);
